// ===== hdl/bcir_pkg.sv
/*
  shared constants for the boost configuration register block:
  target address, register offsets, field positions, reset values
  and strap encodings. assumes a 125 MHz ref_clk.
*/
package bcir_pkg;

  // ==========================================================
  // bus and timing
  // ==========================================================
  localparam logic [6:0] BCIR_TARGET_ADDR = 7'h2C;
  localparam int         BCIR_CLK_MHZ     = 125;
  localparam int         BCIR_RST_MIN_US  = 20;
  localparam int         BCIR_RST_MIN_CYC = BCIR_RST_MIN_US * BCIR_CLK_MHZ;
  localparam logic [3:0] BCIR_SAMPLE_DLY  = 4'h8;

  // ==========================================================
  // register map
  // ==========================================================
  localparam logic [7:0] BCIR_OFS_AC   = 8'h01;
  localparam logic [7:0] BCIR_OFS_HOLD = 8'h03;
  localparam logic [7:0] BCIR_OFS_DC   = 8'h0E;
  localparam int         BCIR_AC_LSB   = 4;
  localparam int         BCIR_HOLD_BIT = 0;
  localparam logic       BCIR_HOLD_RST = 1'b1;

  // ==========================================================
  // encodings
  // ==========================================================
  localparam logic [2:0] BCIR_AC_L0 = 3'h0;
  localparam logic [2:0] BCIR_AC_L1 = 3'h1;
  localparam logic [2:0] BCIR_AC_L2 = 3'h3;
  localparam logic [2:0] BCIR_AC_L3 = 3'h7;
  localparam logic [2:0] BCIR_DC_40 = 3'h3;
  localparam logic [2:0] BCIR_DC_60 = 3'h5;
  localparam logic [2:0] BCIR_DC_80 = 3'h7;
  // tri-level dc strap as seen by the pad comparators
  localparam logic [1:0] BCIR_STRAP_LO  = 2'h0;
  localparam logic [1:0] BCIR_STRAP_MID = 2'h1;
  localparam logic [1:0] BCIR_STRAP_HI  = 2'h2;

  typedef enum logic [2:0] {
    BCIR_IDLE, BCIR_ADDR, BCIR_ACK, BCIR_WDATA, BCIR_RDATA, BCIR_RACK
  } bcir_i2c_st_t;

endpackage

// ===== hdl/bcir_regs.sv
/*
  boost configuration register block: strap latching, mode select,
  i2c target at a fixed address and the three config registers.
  assumes scl/sda/reset_bar_pin/straps are asynchronous pins and the
  pad ring resolves sda from sda_oe (open drain, low when enabled).
*/
module bcir_regs
  import bcir_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // pins
  input  wire logic       reset_bar_pin,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [1:0] ac_boost_strap,
  input  wire logic [1:0] dc_gain_strap,
  // link status from the analog front end
  input  wire logic       link_detect,
  input  wire logic       link_high_speed,
  // to the conditioning path
  output logic            connect_detect_out,
  output logic            boost_enable,
  output logic [2:0]      ac_boost_level,
  output logic [2:0]      dc_gain_level,
  output logic            config_hold
);

  typedef struct packed {
    logic [1:0]   rb_s, scl_s, sda_s;
    logic [1:0]   acs_s0, acs_s1, dcs_s0, dcs_s1;
    logic         scl_d, sda_d;
    logic         active;
    logic [15:0]  low_cnt;
    logic [3:0]   wait_cnt;
    logic         i2c_mode;
    logic [2:0]   ac_q, dc_q;
    logic         hold_q;
    bcir_i2c_st_t st;
    logic [3:0]   bitn;
    logic [7:0]   sh;
    logic         rw, first, addr_ok;
    logic [7:0]   ptr;
    logic         sda_lo;
    logic         cd, boost;
  } bcir_state_t;

  bcir_state_t s_q, s_d;

  logic rb, scl, sda, scl_rise, scl_fall, start, stop;
  logic [7:0] rd_byte;

  assign rb       = s_q.rb_s[1];
  assign scl      = s_q.scl_s[1];
  assign sda      = s_q.sda_s[1];
  assign scl_rise = scl & ~s_q.scl_d;
  assign scl_fall = ~scl & s_q.scl_d;
  assign start    = scl & s_q.scl_d & s_q.sda_d & ~sda;
  assign stop     = scl & s_q.scl_d & ~s_q.sda_d & sda;

  function automatic logic [2:0] ac_code(input logic [1:0] lv);
    case (lv)
      2'h0:    ac_code = BCIR_AC_L0;
      2'h1:    ac_code = BCIR_AC_L1;
      2'h2:    ac_code = BCIR_AC_L2;
      default: ac_code = BCIR_AC_L3;
    endcase
  endfunction

  function automatic logic [2:0] dc_code(input logic [1:0] lv);
    case (lv)
      BCIR_STRAP_LO:  dc_code = BCIR_DC_40;
      BCIR_STRAP_HI:  dc_code = BCIR_DC_80;
      default:        dc_code = BCIR_DC_60;
    endcase
  endfunction

  // reads show live contents, reserved bits zero
  always_comb
  begin
    rd_byte = 8'h00;
    case (s_q.ptr)
      BCIR_OFS_AC:   rd_byte[BCIR_AC_LSB +: 3]  = s_q.ac_q;
      BCIR_OFS_HOLD: rd_byte[BCIR_HOLD_BIT]     = s_q.hold_q;
      BCIR_OFS_DC:   rd_byte[2:0]               = s_q.dc_q;
      default:       rd_byte = 8'h00;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    // ========================================================
    // pin synchronisers
    // ========================================================
    s_d.rb_s   = {s_q.rb_s[0], reset_bar_pin};
    s_d.scl_s  = {s_q.scl_s[0], scl_in};
    s_d.sda_s  = {s_q.sda_s[0], sda_in};
    s_d.acs_s0 = ac_boost_strap;
    s_d.acs_s1 = s_q.acs_s0;
    s_d.dcs_s0 = dc_gain_strap;
    s_d.dcs_s1 = s_q.dcs_s0;
    s_d.scl_d  = scl;
    s_d.sda_d  = sda;

    // ========================================================
    // reset pin: shutdown once the pin has been low for the minimum width
    // ========================================================
    // glitches shorter than the minimum width are ignored
    if (!rb)
    begin
      if (s_q.low_cnt != 16'(BCIR_RST_MIN_CYC))
        s_d.low_cnt = s_q.low_cnt + 16'h0001;
      else
        s_d.active = 1'b0;
    end
    else
      s_d.low_cnt = 16'h0000;

    if (!s_q.active)
    begin
      s_d.cd = 1'b0;
      s_d.boost = 1'b0;
      s_d.st = BCIR_IDLE;
      s_d.sda_lo = 1'b0;
      s_d.i2c_mode = 1'b0;
      if (rb)
      begin
        // short settle, then straps and mode are caught once
        if (s_q.wait_cnt != BCIR_SAMPLE_DLY)
          s_d.wait_cnt = s_q.wait_cnt + 4'h1;
        else
        begin
          s_d.active   = 1'b1;
          s_d.wait_cnt = 4'h0;
          s_d.i2c_mode = scl & sda;
          s_d.ac_q     = ac_code(s_q.acs_s1);
          s_d.dc_q     = dc_code(s_q.dcs_s1);
          s_d.hold_q   = scl & sda;
        end
      end
      else
        s_d.wait_cnt = 4'h0;
    end
    else
    begin
      // link status only while running
      s_d.cd    = link_detect;
      s_d.boost = link_detect & link_high_speed & ~s_q.hold_q;

      // ======================================================
      // i2c target, sampled on ref_clk, 100 kHz bus
      // ======================================================
      if (!s_q.i2c_mode)
        s_d.st = BCIR_IDLE;
      else if (start)
      begin
        s_d.st = BCIR_ADDR;
        s_d.bitn = 4'h0;
        s_d.first = 1'b1;
        s_d.sda_lo = 1'b0;
      end
      else if (stop)
      begin
        s_d.st = BCIR_IDLE;
        s_d.sda_lo = 1'b0;
      end
      else
      begin
        case (s_q.st)
          BCIR_ADDR, BCIR_WDATA:
          begin
            if (scl_rise)
            begin
              s_d.sh = {s_q.sh[6:0], sda};
              s_d.bitn = s_q.bitn + 4'h1;
            end
            if (scl_fall && s_q.bitn == 4'h8)
            begin
              s_d.bitn = 4'h0;
              if (s_q.st == BCIR_ADDR)
              begin
                s_d.addr_ok = (s_q.sh[7:1] == BCIR_TARGET_ADDR);
                s_d.rw = s_q.sh[0];
                s_d.sda_lo = (s_q.sh[7:1] == BCIR_TARGET_ADDR);
                s_d.st = (s_q.sh[7:1] == BCIR_TARGET_ADDR)
                         ? BCIR_ACK : BCIR_IDLE;
              end
              else
              begin
                if (s_q.first)
                  s_d.ptr = s_q.sh;
                else
                begin
                  case (s_q.ptr)
                    BCIR_OFS_AC:   s_d.ac_q = s_q.sh[BCIR_AC_LSB +: 3];
                    BCIR_OFS_HOLD: s_d.hold_q = s_q.sh[BCIR_HOLD_BIT];
                    BCIR_OFS_DC:   s_d.dc_q = s_q.sh[2:0];
                    default:       s_d.ptr = s_q.ptr;
                  endcase
                  s_d.ptr = s_q.ptr + 8'h01;
                end
                s_d.first = 1'b0;
                s_d.sda_lo = 1'b1;
                s_d.st = BCIR_ACK;
              end
            end
          end
          BCIR_ACK:
          begin
            if (scl_fall)
            begin
              if (s_q.rw && s_q.addr_ok && s_q.first)
              begin
                s_d.sh = rd_byte;
                s_d.sda_lo = ~rd_byte[7];
                s_d.bitn = 4'h1;
                s_d.st = BCIR_RDATA;
              end
              else
              begin
                s_d.sda_lo = 1'b0;
                s_d.st = BCIR_WDATA;
              end
              s_d.addr_ok = 1'b0;
            end
          end
          BCIR_RDATA:
          begin
            if (scl_fall)
            begin
              if (s_q.bitn == 4'h8)
              begin
                s_d.sda_lo = 1'b0;
                s_d.ptr = s_q.ptr + 8'h01;
                s_d.st = BCIR_RACK;
              end
              else
              begin
                s_d.sda_lo = ~s_q.sh[7 - 3'(s_q.bitn)];
                s_d.bitn = s_q.bitn + 4'h1;
              end
            end
          end
          BCIR_RACK:
          begin
            if (scl_rise)
              s_d.rw = ~sda;
            if (scl_fall)
            begin
              if (s_q.rw)
              begin
                s_d.sh = rd_byte;
                s_d.sda_lo = ~rd_byte[7];
                s_d.bitn = 4'h1;
                s_d.st = BCIR_RDATA;
              end
              else
                s_d.st = BCIR_IDLE;
            end
          end
          default: s_d.st = BCIR_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.hold_q <= BCIR_HOLD_RST;
      s_q.dc_q <= BCIR_DC_60;
      s_q.st <= BCIR_IDLE;
    end
    else
      s_q <= s_d;
  end

  assign sda_out            = 1'b0;
  assign sda_oe             = s_q.sda_lo;
  assign connect_detect_out = s_q.cd;
  assign boost_enable       = s_q.boost;
  assign ac_boost_level     = s_q.ac_q;
  assign dc_gain_level      = s_q.dc_q;
  assign config_hold        = s_q.hold_q;

endmodule

// ===== testbench/bcir_regs_asserts.sv
/* checker for bcir_regs, bound to its ports.
   assumes one ref_clk domain and rst active high. */
module bcir_regs_asserts (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // pins
  input wire logic       reset_bar_pin,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [1:0] ac_boost_strap,
  input wire logic [1:0] dc_gain_strap,
  input wire logic       link_detect,
  input wire logic       link_high_speed,
  // outputs
  input wire logic       connect_detect_out,
  input wire logic       boost_enable,
  input wire logic [2:0] ac_boost_level,
  input wire logic [2:0] dc_gain_level,
  input wire logic       config_hold
);
  timeunit 1ns;
  timeprecision 10ps;
  // ==========================================
  // helpers
  // ==========================================
  // saturating count of reset pin low cycles
  logic [11:0] low_q;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      low_q <= 12'h000;
    else
      low_q <= reset_bar_pin ? 12'h000 : low_q + {11'h0, ~&low_q};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // assertions
  // ==========================================
  a_rst_values: assert property ($fell(rst) |->
    config_hold && dc_gain_level == 3'h5) else $error("bad reset values");
  a_rst_quiet: assert property ($fell(rst) |->
    !connect_detect_out && !boost_enable && !sda_oe) else $error("active");
  a_sda_drain: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  a_ack_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("sda pulled while scl high");
  a_release_low: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("sda released while scl high");
  a_hold_blocks: assert property (config_hold && $past(config_hold)
    |-> !boost_enable) else $error("boost during hold");
  a_hs_only: assert property (!link_high_speed [*3]
    |-> !boost_enable) else $error("boost without hs");
  a_cd_drops: assert property (!link_detect [*3]
    |-> !connect_detect_out) else $error("detect without link");
  a_shutdown: assert property (low_q > 12'hA00 |->
    !connect_detect_out && !boost_enable) else $error("not shut down");
  c_boost: cover property ($rose(boost_enable));
  c_hold_clear: cover property ($fell(config_hold));
  c_ack: cover property ($rose(sda_oe));
endmodule
bind bcir_regs bcir_regs_asserts u_asserts (.ref_clk, .rst, .reset_bar_pin,
  .scl_in, .sda_in, .sda_out, .sda_oe, .ac_boost_strap, .dc_gain_strap,
  .link_detect, .link_high_speed, .connect_detect_out, .boost_enable,
  .ac_boost_level, .dc_gain_level, .config_hold);

// ===== testbench/bcir_i2c_ctl.sv
/* i2c controller model: bit-banged scl, open-drain pull on sda.
   assumes the bench resolves sda with a pull-up. */
module bcir_i2c_ctl (
  // bus pins
  output logic      scl_in,
  output logic      m_low,
  input  wire logic sda_in
);
  timeunit 1ns;
  timeprecision 10ps;
  // quarter of a 125 ns scl period; faster than 100 kHz to keep runs short
  localparam realtime Q = 31.25;
  initial scl_in = 1'b1;
  initial m_low = 1'b0;
  // ==========================================
  // conditions and bytes
  // ==========================================
  task automatic start();
    #Q m_low = 1'b0;
    #Q scl_in = 1'b1;
    #Q m_low = 1'b1;
    #Q scl_in = 1'b0;
  endtask
  task automatic stop();
    #Q m_low = 1'b1;
    #Q scl_in = 1'b1;
    #Q m_low = 1'b0;
  endtask
  task automatic bit_io(input logic b, output logic r);
    #Q m_low = ~b;
    #Q scl_in = 1'b1;
    #Q r = sda_in;
    #Q scl_in = 1'b0;
  endtask
  // msb first; ninth bit is the acknowledge
  task automatic xfer(input logic [7:0] w, input logic m,
                      output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(w[i], r[i]);
    bit_io(m, a);
  endtask
endmodule

// ===== testbench/tb_boost_config_i2c_regs.sv
/* bench for bcir_regs: register traffic over i2c, straps and mode
   through the reset pin. assumes bcir_i2c_ctl as the controller. */
module tb_boost_config_i2c_regs;
  timeunit 1ns;
  timeprecision 10ps;
  import bcir_pkg::*;
  logic       ref_clk, rst, reset_bar_pin, scl_in, sda_in, m_low, nak;
  logic       sda_out, sda_oe, link_detect, link_high_speed;
  logic       connect_detect_out, boost_enable, config_hold;
  logic [1:0] ac_boost_strap, dc_gain_strap;
  logic [2:0] ac_boost_level, dc_gain_level;
  logic [6:0] tgt;
  logic [7:0] d;
  int         mismatches, tests_run;
  logic [2:0] acc [4] = '{BCIR_AC_L0, BCIR_AC_L1, BCIR_AC_L2, BCIR_AC_L3};
  logic [2:0] dcc [3] = '{BCIR_DC_80, BCIR_DC_60, BCIR_DC_40};
  assign sda_in = ~((sda_oe & ~sda_out) | m_low);
  bcir_regs dut (.ref_clk, .rst, .reset_bar_pin, .scl_in, .sda_in,
    .sda_out, .sda_oe, .ac_boost_strap, .dc_gain_strap, .link_detect,
    .link_high_speed, .connect_detect_out, .boost_enable,
    .ac_boost_level, .dc_gain_level, .config_hold);
  bcir_i2c_ctl ctl (.scl_in, .m_low, .sda_in);
  // ==========================================
  // tasks
  // ==========================================
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic byt(input logic [7:0] w);
    logic [7:0] r;
    logic       a;
    ctl.xfer(w, 1'b1, r, a);
    nak = nak | a;
  endtask
  task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] v);
    ctl.start();
    byt({tgt, 1'b0});
    byt(ofs);
    byt(v);
    ctl.stop();
  endtask
  task automatic reg_rd(input logic [7:0] ofs);
    logic a;
    ctl.start();
    byt({tgt, 1'b0});
    byt(ofs);
    ctl.start();
    byt({tgt, 1'b1});
    ctl.xfer(8'hFF, 1'b1, d, a);
    ctl.stop();
  endtask
  task automatic pin_reset(input logic i2c, input logic [1:0] a,
                           input logic [1:0] c);
    @(negedge ref_clk);
    reset_bar_pin = 1'b0;
    ac_boost_strap = a;
    dc_gain_strap = c;
    ctl.m_low = ~i2c;
    repeat (2600) @(negedge ref_clk);
    chk({7'h0, connect_detect_out}, 8'h00);
    reset_bar_pin = 1'b1;
    repeat (24) @(negedge ref_clk);
    ctl.m_low = 1'b0;
    nak = 1'b0;
  endtask
  // ==========================================
  // clock, watchdog, sequence
  // ==========================================
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    conclude();
  end
  initial
  begin
    rst = 1'b1;
    reset_bar_pin = 1'b0;
    ac_boost_strap = 2'h2;
    dc_gain_strap = 2'h0;
    link_detect = 1'b1;
    link_high_speed = 1'b1;
    tgt = BCIR_TARGET_ADDR;
    nak = 1'b0;
    repeat (20) @(negedge ref_clk);
    chk({4'h0, config_hold, dc_gain_level}, 8'h0D);
    rst = 1'b0;
    pin_reset(1'b1, 2'h2, 2'h0);
    reg_rd(BCIR_OFS_AC);
    chk(d, 8'h30);
    reg_rd(BCIR_OFS_HOLD);
    chk(d, 8'h01);
    reg_rd(BCIR_OFS_DC);
    chk(d, 8'h03);
    chk({6'h0, boost_enable, nak}, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      reg_rd(BCIR_OFS_AC);
      reg_wr(BCIR_OFS_AC, {d[7], acc[i], d[3:0]});
      reg_rd(BCIR_OFS_AC);
      chk({1'b0, ac_boost_level, 1'b0, d[6:4]}, {2{1'b0, acc[i]}});
    end
    for (int i = 0; i < 3; i++)
    begin
      reg_rd(BCIR_OFS_DC);
      reg_wr(BCIR_OFS_DC, {d[7:3], dcc[i]});
      reg_rd(BCIR_OFS_DC);
      chk({1'b0, dc_gain_level, 1'b0, d[2:0]}, {2{1'b0, dcc[i]}});
    end
    reg_wr(BCIR_OFS_HOLD, 8'h01);
    reg_wr(BCIR_OFS_HOLD, 8'h00);
    chk({4'h0, nak, config_hold, connect_detect_out, boost_enable},
        8'h03);
    @(negedge ref_clk);
    link_high_speed = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk({6'h0, connect_detect_out, boost_enable}, 8'h02);
    link_detect = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk({7'h0, connect_detect_out}, 8'h00);
    link_detect = 1'b1;
    tgt = 7'h2D;
    reg_wr(BCIR_OFS_AC, 8'h00);
    chk({7'h0, nak}, 8'h01);
    tgt = BCIR_TARGET_ADDR;
    @(negedge ref_clk);
    ac_boost_strap = 2'h1;
    dc_gain_strap = 2'h2;
    repeat (40) @(negedge ref_clk);
    chk({1'b0, ac_boost_level, 1'b0, dc_gain_level}, 8'h73);
    pin_reset(1'b0, 2'h1, 2'h2);
    chk({config_hold, ac_boost_level, 1'b0, dc_gain_level},
        8'h17);
    reg_rd(BCIR_OFS_HOLD);
    chk({7'h0, nak}, 8'h01);
    pin_reset(1'b0, 2'h3, 2'h1);
    chk({config_hold, ac_boost_level, 1'b0, dc_gain_level},
        8'h75);
    conclude();
  end
endmodule
